// File: src/ddsc_params.svh
// Purpose: constants for the digital input debounce, edge counter and DAC slew register bank
// Assumes: 100 MHz ref_clk and byte-wide register addresses
// Notes:   all offsets, field positions, reset values and timing counts live here
`ifndef DDSC_PARAMS_SVH
`define DDSC_PARAMS_SVH

// register offsets
`define DDSC_ADDR_DIN1         8'h04
`define DDSC_ADDR_DIN2         8'h05
`define DDSC_ADDR_OUT          8'h06
`define DDSC_ADDR_COUNT        8'h10
// reset values
`define DDSC_RST_DIN1          16'h000b
`define DDSC_RST_DIN2          16'h0000
`define DDSC_RST_OUT           16'h0000
// writable bit masks, reserved bits read zero
`define DDSC_MASK_DIN1         16'hffdf
`define DDSC_MASK_DIN2         16'h07ff
`define DDSC_MASK_OUT          16'h00ff
// first input register fields
`define DDSC_B_COUNT_EN        15
`define DDSC_B_INVERT          14
`define DDSC_B_COMP_EN         13
`define DDSC_B_SINK_SCALE      12
`define DDSC_F_SINK_HI         11
`define DDSC_F_SINK_LO         7
`define DDSC_B_DEB_MODE        6
`define DDSC_F_DEB_HI          4
`define DDSC_F_DEB_LO          0
// second input register fields
`define DDSC_B_UNBUF           10
`define DDSC_B_SHORT_DET       9
`define DDSC_B_OPEN_DET        8
`define DDSC_B_THR_REF         7
`define DDSC_F_THR_HI          6
`define DDSC_F_THR_LO          0
// output register fields
`define DDSC_B_VOUT_SPAN       7
`define DDSC_F_SLEW_HI         6
`define DDSC_F_SLEW_LO         5
`define DDSC_F_STEP_HI         4
`define DDSC_F_STEP_LO         3
`define DDSC_F_RATE_HI         2
`define DDSC_F_RATE_LO         1
`define DDSC_B_ILIMIT          0
// slew select codes
`define DDSC_SLEW_NONE         2'h0
`define DDSC_SLEW_LINEAR       2'h1
`define DDSC_SLEW_MODEM        2'h2
// debounce codes and timing
`define DDSC_DEB_BYPASS        5'h00
`define DDSC_DEB_RESET_CODE    5'h0b
`define DDSC_DEB_RESET_US      240
`define DDSC_DEB_STEP_US       20
`define DDSC_CLK_NS            10
`define DDSC_TICK_NS           1000
`define DDSC_TICK_CYCLES       (`DDSC_TICK_NS / `DDSC_CLK_NS)
// linear slew step sizes, codes of a 14-bit full scale
`define DDSC_STEP0             15'h0083
`define DDSC_STEP1             15'h00f6
`define DDSC_STEP2             15'h03e7
`define DDSC_STEP3             15'h0e35
// linear slew update rates, period rounded down to whole cycles
`define DDSC_RATE0_HZ          4000
`define DDSC_RATE1_HZ          64000
`define DDSC_RATE2_HZ          150000
`define DDSC_RATE3_HZ          240000
`define DDSC_HZ_TO_CYC(f)      (1000000000 / ((f) * `DDSC_CLK_NS))

`endif

// File: src/ddsc_pkg.sv
// Purpose: shared types for the register bank and slew engine
// Assumes: 14-bit DAC code, 16-bit registers
// Notes:   constants are in ddsc_params.svh
package ddsc_pkg;
   typedef logic [15:0] ddsc_word_t;   // one register
   typedef logic [13:0] ddsc_dac_t;    // one dac code
   typedef enum logic {SL_IDLE, SL_RUN} ddsc_slew_state_t;  // slew engine state
endpackage : ddsc_pkg

// File: src/ddsc_slew.sv
// Purpose: moves the active dac code toward the target under the selected slew mode
// Assumes: target_load pulses when software writes a new target
// Notes:   modem slewing uses the smallest step at the slowest rate
`timescale 1ns/100ps
`default_nettype none
`include "ddsc_params.svh"
module ddsc_slew
   import ddsc_pkg::*;
#(
   parameter int RATE0_CYCLES = `DDSC_HZ_TO_CYC(`DDSC_RATE0_HZ)
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // configuration
   input  wire logic [1:0] slew_sel,
   input  wire logic [1:0] step_sel,
   input  wire logic [1:0] rate_sel,
   // target
   input  wire ddsc_dac_t  target,
   input  wire logic       target_load,
   // active code
   output var  ddsc_dac_t  dac_code_ff
);
   // update period per rate code
   function automatic logic [14:0] rate_cyc(input logic [1:0] r);
      unique case (r)
         2'h0: rate_cyc = 15'(RATE0_CYCLES);
         2'h1: rate_cyc = 15'(`DDSC_HZ_TO_CYC(`DDSC_RATE1_HZ));
         2'h2: rate_cyc = 15'(`DDSC_HZ_TO_CYC(`DDSC_RATE2_HZ));
         2'h3: rate_cyc = 15'(`DDSC_HZ_TO_CYC(`DDSC_RATE3_HZ));
      endcase
   endfunction : rate_cyc

   // step size per step code
   function automatic logic [14:0] step_sz(input logic [1:0] s);
      unique case (s)
         2'h0: step_sz = `DDSC_STEP0;
         2'h1: step_sz = `DDSC_STEP1;
         2'h2: step_sz = `DDSC_STEP2;
         2'h3: step_sz = `DDSC_STEP3;
      endcase
   endfunction : step_sz

   logic [14:0]      tick_cnt_ff;   // update tick prescaler
   ddsc_slew_state_t state_ff;      // idle or moving
   wire logic        is_lin  = (slew_sel == `DDSC_SLEW_LINEAR);
   wire logic        is_mod  = (slew_sel == `DDSC_SLEW_MODEM);
   wire logic        active  = is_lin | is_mod;
   wire logic [14:0] period  = is_mod ? rate_cyc(2'h0) : rate_cyc(rate_sel);
   wire logic [14:0] step    = is_mod ? step_sz(2'h0) : step_sz(step_sel);
   wire logic        tick    = active & (tick_cnt_ff >= period - 15'h0001);
   wire logic        up      = (target > dac_code_ff);
   wire logic [14:0] gap     = up ? 15'({1'b0, target} - {1'b0, dac_code_ff})
                                  : 15'({1'b0, dac_code_ff} - {1'b0, target});
   wire logic        land    = (gap <= step);
   wire logic [14:0] moved   = up ? 15'({1'b0, dac_code_ff} + step)
                                  : 15'({1'b0, dac_code_ff} - step);
   // next code: exact landing, no overshoot
   wire ddsc_dac_t   nxt_code = land ? target : moved[13:0];
   wire ddsc_slew_state_t nxt_state = (active && target != dac_code_ff) ? SL_RUN : SL_IDLE;

   // prescaler; stops when slewing is off
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) tick_cnt_ff <= 15'h0000;
      else if (!active || tick) tick_cnt_ff <= 15'h0000;
      else tick_cnt_ff <= tick_cnt_ff + 15'h0001;
   end

   // active code update
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dac_code_ff <= '0;
         state_ff    <= SL_IDLE;
      end else begin
         state_ff <= nxt_state;
         if (!active && target_load) dac_code_ff <= target;  // direct load
         else if (state_ff == SL_RUN && tick) dac_code_ff <= nxt_code;
      end
   end

   // no code change while slewing is off, except a direct load
   slew_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!$past(active) && !$past(target_load)) |-> $stable(dac_code_ff))
      else $error("dac code moved with slewing off");
   // linear slew never passes the target on the way up
   no_overshoot_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ($past(is_lin) && $past(up) && $changed(dac_code_ff)) |-> dac_code_ff <= $past(target))
      else $error("linear slew overshot target");
endmodule : ddsc_slew
`default_nettype wire

// File: src/ddsc_top.sv
// Purpose: digital input and output setup registers with debounce, edge counter and slew
// Assumes: register access and comparator input synchronous to ref_clk
// Notes:   analog paths only see the register fields on the setup register outputs
`timescale 1ns/100ps
`default_nettype none
`include "ddsc_params.svh"
module ddsc_top
   import ddsc_pkg::*;
#(
   parameter int RATE0_CYCLES  = `DDSC_HZ_TO_CYC(`DDSC_RATE0_HZ),
   parameter int DEB_RESET_US  = `DDSC_DEB_RESET_US,
   parameter int DEB_STEP_US   = `DDSC_DEB_STEP_US
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // register access
   input  wire logic [7:0] reg_addr,
   input  wire ddsc_word_t reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  ddsc_word_t reg_rdata_ff,
   // channel function register write event
   input  wire logic       chfunc_wr,
   input  wire logic       chfunc_comp_en,
   // comparator and dac target
   input  wire logic       comp_raw,
   input  wire ddsc_dac_t  dac_target,
   input  wire logic       dac_target_load,
   // register contents to the analog side
   output var  ddsc_word_t din_setup_one_ff,
   output var  ddsc_word_t din_setup_two_ff,
   output var  ddsc_word_t output_setup_ff,
   // digital input state
   output var  logic       din_debounced_ff,
   output var  ddsc_word_t edge_count_ff,
   // active dac code
   output var  ddsc_dac_t  dac_code_ff
);
   // debounce threshold in microsecond ticks per time code
   function automatic logic [11:0] deb_thr(input logic [4:0] c);
      if (c == `DDSC_DEB_RESET_CODE) deb_thr = 12'(DEB_RESET_US);
      else deb_thr = 12'(DEB_STEP_US * int'(c));
   endfunction : deb_thr

   // register decode
   wire logic wr_din1 = reg_wr & (reg_addr == `DDSC_ADDR_DIN1);
   wire logic wr_din2 = reg_wr & (reg_addr == `DDSC_ADDR_DIN2);
   wire logic wr_out  = reg_wr & (reg_addr == `DDSC_ADDR_OUT);

   // field views
   wire logic       cnt_en   = din_setup_one_ff[`DDSC_B_COUNT_EN];
   wire logic       inv      = din_setup_one_ff[`DDSC_B_INVERT];
   wire logic       comp_en  = din_setup_one_ff[`DDSC_B_COMP_EN];
   wire logic       deb_mode = din_setup_one_ff[`DDSC_B_DEB_MODE];
   wire logic [4:0] deb_code = din_setup_one_ff[`DDSC_F_DEB_HI:`DDSC_F_DEB_LO];
   wire logic [11:0] thr     = deb_thr(deb_code);

   // first input register, next value
   wire ddsc_word_t din1_wr   = reg_wdata & `DDSC_MASK_DIN1;
   wire ddsc_word_t din1_base = wr_din1 ? din1_wr : din_setup_one_ff;
   logic [15:0]     nxt_din1;
   always_comb begin
      nxt_din1 = din1_base;
      if (chfunc_wr) begin
         nxt_din1[`DDSC_F_SINK_HI:`DDSC_F_SINK_LO] = 5'h00;
         nxt_din1[`DDSC_B_COMP_EN] = chfunc_comp_en;
      end
   end

   // register storage; fields drive the analog side directly
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         din_setup_one_ff <= `DDSC_RST_DIN1;
         din_setup_two_ff <= `DDSC_RST_DIN2;
         output_setup_ff  <= `DDSC_RST_OUT;
      end else begin
         din_setup_one_ff <= nxt_din1;
         if (wr_din2) din_setup_two_ff <= reg_wdata & `DDSC_MASK_DIN2;
         if (wr_out)  output_setup_ff  <= reg_wdata & `DDSC_MASK_OUT;
      end
   end

   // read mux, unmapped reads zero
   wire ddsc_word_t nxt_rdata =
      (reg_addr == `DDSC_ADDR_DIN1)  ? din_setup_one_ff :
      (reg_addr == `DDSC_ADDR_DIN2)  ? din_setup_two_ff :
      (reg_addr == `DDSC_ADDR_OUT)   ? output_setup_ff  :
      (reg_addr == `DDSC_ADDR_COUNT) ? edge_count_ff    : 16'h0000;

   // read data register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) reg_rdata_ff <= 16'h0000;
      else if (reg_rd) reg_rdata_ff <= nxt_rdata;
   end

   // comparator after enable and inversion
   wire logic din_pre = comp_en & (comp_raw ^ inv);

   // microsecond tick for debounce
   logic [11:0] pre_cnt_ff;  // tick prescaler
   wire logic   us_tick = (pre_cnt_ff == 12'(`DDSC_TICK_CYCLES - 1));
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) pre_cnt_ff <= 12'h000;
      else if (us_tick) pre_cnt_ff <= 12'h000;
      else pre_cnt_ff <= pre_cnt_ff + 12'h001;
   end

   // debounce counter next value
   logic [11:0] deb_cnt_ff;   // debounce counter
   logic [11:0] nxt_deb_cnt;
   logic        nxt_deb_out;
   always_comb begin
      nxt_deb_cnt = deb_cnt_ff;
      nxt_deb_out = din_debounced_ff;
      if (deb_code == `DDSC_DEB_BYPASS) begin
         nxt_deb_cnt = 12'h000;
         nxt_deb_out = din_pre;
      end else if (deb_mode) begin
         // simple counter: clears at once on deassert
         if (!din_pre) nxt_deb_cnt = 12'h000;
         else if (us_tick && deb_cnt_ff < thr) nxt_deb_cnt = deb_cnt_ff + 12'h001;
         nxt_deb_out = din_pre & (nxt_deb_cnt >= thr);
      end else begin
         // integrator: up while asserted, down while not
         if (us_tick && din_pre && deb_cnt_ff < thr) nxt_deb_cnt = deb_cnt_ff + 12'h001;
         else if (us_tick && !din_pre && deb_cnt_ff != 12'h000)
            nxt_deb_cnt = deb_cnt_ff - 12'h001;
         if (nxt_deb_cnt >= thr) nxt_deb_out = 1'b1;
         else if (nxt_deb_cnt == 12'h000) nxt_deb_out = 1'b0;
      end
   end

   // debounce state
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         deb_cnt_ff       <= 12'h000;
         din_debounced_ff <= 1'b0;
      end else begin
         deb_cnt_ff       <= nxt_deb_cnt;
         din_debounced_ff <= nxt_deb_out;
      end
   end

   // edge detect on the debounced input
   logic      deb_prev_ff;  // debounced value one cycle back
   wire logic rise    = din_debounced_ff & ~deb_prev_ff;
   wire logic fall    = ~din_debounced_ff & deb_prev_ff;
   wire logic cnt_inc = cnt_en & (inv ? fall : rise);

   // edge counter
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         deb_prev_ff   <= 1'b0;
         edge_count_ff <= 16'h0000;
      end else begin
         deb_prev_ff <= din_debounced_ff;
         if (cnt_inc) edge_count_ff <= edge_count_ff + 16'h0001;
      end
   end

   // dac slew engine
   ddsc_slew #(
      .RATE0_CYCLES (RATE0_CYCLES)
   ) u_slew (
      .ref_clk     (ref_clk),
      .rst_b       (rst_b),
      .slew_sel    (output_setup_ff[`DDSC_F_SLEW_HI:`DDSC_F_SLEW_LO]),
      .step_sel    (output_setup_ff[`DDSC_F_STEP_HI:`DDSC_F_STEP_LO]),
      .rate_sel    (output_setup_ff[`DDSC_F_RATE_HI:`DDSC_F_RATE_LO]),
      .target      (dac_target),
      .target_load (dac_target_load),
      .dac_code_ff (dac_code_ff)
   );

   // rising edges counted when not inverted
   count_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (cnt_en && !inv && din_debounced_ff && !deb_prev_ff) |=>
         edge_count_ff == $past(edge_count_ff) + 16'h0001)
      else $error("rising edge not counted");
   // falling edges counted when inverted
   count_fall_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (cnt_en && inv && !din_debounced_ff && deb_prev_ff) |=>
         edge_count_ff == $past(edge_count_ff) + 16'h0001)
      else $error("falling edge not counted");
   // counter register readable
   count_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == `DDSC_ADDR_COUNT) |=> reg_rdata_ff == $past(edge_count_ff))
      else $error("counter read wrong");
   // channel write clears sink code
   sink_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      chfunc_wr |=> din_setup_one_ff[`DDSC_F_SINK_HI:`DDSC_F_SINK_LO] == 5'h00)
      else $error("sink code not cleared");
   // channel write sets comparator enable
   comp_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      chfunc_wr |=> din_setup_one_ff[`DDSC_B_COMP_EN] == $past(chfunc_comp_en))
      else $error("comparator enable not updated");
   // bypass passes comparator straight through
   deb_bypass_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (deb_code == `DDSC_DEB_BYPASS) |=> din_debounced_ff == $past(comp_en & (comp_raw ^ inv)))
      else $error("bypass output wrong");
   // mode 1 clears on deassert
   deb_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (deb_mode && deb_code != `DDSC_DEB_BYPASS && !din_pre) |=>
         (deb_cnt_ff == 12'h000 && !din_debounced_ff))
      else $error("mode 1 did not clear");
   // integrator counts down by one per tick
   deb_down_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!deb_mode && deb_code != `DDSC_DEB_BYPASS && us_tick && !din_pre &&
       deb_cnt_ff != 12'h000) |=> deb_cnt_ff == $past(deb_cnt_ff) - 12'h001)
      else $error("integrator did not count down");
   // output register keeps reserved bits zero
   out_reserved_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      wr_out |=> output_setup_ff == ($past(reg_wdata) & `DDSC_MASK_OUT))
      else $error("output register write wrong");
endmodule : ddsc_top
`default_nettype wire

// File: verification/ddsc_host.sv
// Purpose: host side model that issues register writes and reads
// Assumes: strobes are one-cycle pulses launched at the falling edge
// Notes:   rd_valid marks the cycle in which read data is settled
`timescale 1ns/100ps
`default_nettype none
module ddsc_host
   import ddsc_pkg::*;
(
   // clock
   input  wire logic       ref_clk,
   // register access
   output var  logic [7:0] reg_addr,
   output var  ddsc_word_t reg_wdata,
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   // read data settled
   output var  logic       rd_valid
);
   // idle bus at time zero
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      rd_valid  = 1'b0;
   end

   // one write strobe, taken at the next rising edge
   task automatic wr(input logic [7:0] a, input ddsc_word_t d);
      @(negedge ref_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge ref_clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask : wr

   // one read strobe, data settles one cycle later
   task automatic rd(input logic [7:0] a);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge ref_clk);
      reg_rd   = 1'b0;
      rd_valid = 1'b1;
      @(negedge ref_clk);
      rd_valid = 1'b0;
   endtask : rd
endmodule : ddsc_host
`default_nettype wire

// File: verification/ddsc_top_tb.sv
// Purpose: self-checking bench for the setup registers, debounce, counter and slew
// Assumes: shortened tick counts through parameters
// Notes:   reads are checked against a queue of expected words
`timescale 1ns/100ps
`default_nettype none
`include "ddsc_params.svh"
module ddsc_top_tb;
   import ddsc_pkg::*;
   // register access and stimulus
   logic       ref_clk, rst_b, chfunc_wr, chfunc_comp_en, comp_raw, dac_target_load;
   logic [7:0] reg_addr;
   logic       reg_wr, reg_rd, rd_valid;
   ddsc_word_t reg_wdata, reg_rdata_ff, s1, s2, s3, cnt, rnd;
   ddsc_dac_t  dac_target, dac_code_ff, held;
   logic       din_debounced_ff;
   int         fails, num_checks, i;
   int         seed = 32'h7516;
   ddsc_word_t expq[$];   // expected read words, oldest first

   ddsc_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .rd_valid(rd_valid));

   ddsc_top #(.RATE0_CYCLES(50), .DEB_RESET_US(3), .DEB_STEP_US(2)) uut (
      .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .chfunc_wr(chfunc_wr), .chfunc_comp_en(chfunc_comp_en), .comp_raw(comp_raw),
      .dac_target(dac_target), .dac_target_load(dac_target_load),
      .din_setup_one_ff(s1), .din_setup_two_ff(s2), .output_setup_ff(s3),
      .din_debounced_ff(din_debounced_ff), .edge_count_ff(cnt), .dac_code_ff(dac_code_ff));

   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // compare and count
   task automatic check(input ddsc_word_t got, input ddsc_word_t exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // verdict and end of run
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report

   // read monitor takes the oldest note
   always @(posedge ref_clk) begin
      if (rd_valid === 1'b1) begin
         if (expq.size() == 0) begin
            // a read with no note is always a mismatch, unknown data too
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, reg_rdata_ff, 16'h0000);
         end
         else check(reg_rdata_ff, expq.pop_front());
      end
   end

   // note an expected word, then read
   task automatic rd_exp(input logic [7:0] a, input ddsc_word_t e);
      expq.push_back(e);
      host.rd(a);
   endtask : rd_exp

   // wait n falling edges
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc

   // bounded wait for a dac code, no overshoot on the way up
   task automatic wait_dac(input ddsc_dac_t v, input int n);
      int k;
      for (k = 0; k < n && dac_code_ff !== v; k++) begin
         @(negedge ref_clk);
         if (dac_code_ff > v) check({2'b00, dac_code_ff}, {2'b00, v});
      end
      check({2'b00, dac_code_ff}, {2'b00, v});
      if (dac_code_ff !== v) final_report();
   endtask : wait_dac

   // comparator pulses, low then high
   task automatic pulse_low(input int n);
      repeat (n) begin
         comp_raw = 1'b0;
         cyc(3);
         comp_raw = 1'b1;
         cyc(3);
      end
   endtask : pulse_low

   initial begin
      rst_b = 1'b0; chfunc_wr = 1'b0; chfunc_comp_en = 1'b0; comp_raw = 1'b0;
      dac_target = 14'h0000; dac_target_load = 1'b0; fails = 0; num_checks = 0;
      cyc(6);
      rst_b = 1'b1;
      rd_exp(`DDSC_ADDR_DIN1, 16'h000b);
      rd_exp(`DDSC_ADDR_DIN2, 16'h0000);
      rd_exp(`DDSC_ADDR_OUT, 16'h0000);
      $display("test reset done");
      // integrator: slow rise, slow fall, threshold 2 ticks
      comp_raw = 1'b1;
      host.wr(`DDSC_ADDR_DIN1, 16'h2001);
      cyc(50); check({15'h0, din_debounced_ff}, 16'h0000);
      cyc(300); check({15'h0, din_debounced_ff}, 16'h0001);
      comp_raw = 1'b0;
      cyc(50); check({15'h0, din_debounced_ff}, 16'h0001);
      cyc(300); check({15'h0, din_debounced_ff}, 16'h0000);
      // simple counter mode clears at once
      host.wr(`DDSC_ADDR_DIN1, 16'h2041);
      comp_raw = 1'b1;
      cyc(350); check({15'h0, din_debounced_ff}, 16'h0001);
      comp_raw = 1'b0;
      cyc(3); check({15'h0, din_debounced_ff}, 16'h0000);
      // bypass passes comparator straight through
      host.wr(`DDSC_ADDR_DIN1, 16'h2000);
      comp_raw = 1'b1;
      cyc(2); check({15'h0, din_debounced_ff}, 16'h0001);
      $display("test debounce done");
      // rising edges counted
      host.wr(`DDSC_ADDR_DIN1, 16'ha000);
      pulse_low(3);
      rd_exp(`DDSC_ADDR_COUNT, 16'h0003);
      // inverted: the switch itself is one falling edge, then two more
      host.wr(`DDSC_ADDR_DIN1, 16'he000);
      cyc(3); check({15'h0, din_debounced_ff}, 16'h0000);
      pulse_low(2);
      rd_exp(`DDSC_ADDR_COUNT, 16'h0006);
      host.wr(`DDSC_ADDR_COUNT, 16'hffff);
      rd_exp(`DDSC_ADDR_COUNT, 16'h0006);
      check(cnt, 16'h0006);
      $display("test counter done");
      // linear slew, rate 11 step 00, then step 01
      dac_target = 14'd100;
      host.wr(`DDSC_ADDR_OUT, 16'h0026);
      wait_dac(14'd100, 1000);
      dac_target = 14'd600;
      host.wr(`DDSC_ADDR_OUT, 16'h002e);
      wait_dac(14'd600, 1500);
      // rate 00 is fast here, three steps of 131
      dac_target = 14'd993;
      host.wr(`DDSC_ADDR_OUT, 16'h0020);
      wait_dac(14'd993, 200);
      // slew off mid-run freezes the code
      dac_target = 14'd9000;
      cyc(120);
      host.wr(`DDSC_ADDR_OUT, 16'h0000);
      cyc(2);
      held = dac_code_ff;
      cyc(300); check({2'b00, dac_code_ff}, {2'b00, held});
      dac_target = 14'd50;
      dac_target_load = 1'b1;
      cyc(1);
      dac_target_load = 1'b0;
      cyc(1); check({2'b00, dac_code_ff}, 16'd50);
      // modem slewing: smallest step at the rate 00 period, linear fields ignored
      dac_target = 14'd312;
      host.wr(`DDSC_ADDR_OUT, 16'h005e);
      cyc(60); check({2'b00, dac_code_ff}, 16'd181);
      wait_dac(14'd312, 100);
      $display("test slew done");
      // writable masks and random words
      host.wr(`DDSC_ADDR_DIN1, 16'hffff);
      host.wr(`DDSC_ADDR_OUT, 16'hffff);
      rd_exp(`DDSC_ADDR_DIN1, `DDSC_MASK_DIN1);
      rd_exp(`DDSC_ADDR_OUT, `DDSC_MASK_OUT);
      check(s1, `DDSC_MASK_DIN1);
      check(s3, `DDSC_MASK_OUT);
      for (i = 0; i < 4; i++) begin
         rnd = 16'($random(seed));
         host.wr(`DDSC_ADDR_DIN2, rnd);
         rd_exp(`DDSC_ADDR_DIN2, rnd & `DDSC_MASK_DIN2);
         check(s2, rnd & `DDSC_MASK_DIN2);
      end
      // channel function write clears sink code and sets comparator enable
      chfunc_comp_en = 1'b0;
      chfunc_wr = 1'b1;
      cyc(1);
      chfunc_wr = 1'b0;
      rd_exp(`DDSC_ADDR_DIN1, 16'hd05f);
      chfunc_comp_en = 1'b1;
      chfunc_wr = 1'b1;
      cyc(1);
      chfunc_wr = 1'b0;
      rd_exp(`DDSC_ADDR_DIN1, 16'hf05f);
      host.wr(8'h20, 16'h1234);
      rd_exp(8'h20, 16'h0000);
      rd_exp(`DDSC_ADDR_DIN2, rnd & `DDSC_MASK_DIN2);
      cyc(3);
      $display("test registers done");
      final_report();
   end
endmodule : ddsc_top_tb
`default_nettype wire
